// ===== logic/dfg_gate.sv
// directional release gate for a residual overcurrent stage, avalon-mm slave
`timescale 1ns/100ps

// Behaviour
// - decisions use fundamental phasors of residual current and voltage
// - directional selections release only if both quantities suffice and angle sits in window
// - residual current is negated; forward means fault on protected line
// - minimum voltage setting, percent, 1 to 20, default 2
// - minimum current setting, percent, 1 to 50, default 5
// - decision enable only while both magnitudes exceed their minimums
// - angle of current measured with the voltage phasor as reference
// - both magnitude enables are ANDed before the decision
// - non-directional selection forces the decision true
// - nine direction selections, default forward angle
// - forward angle uses user centre and half width
// - backward angle uses user centre plus 180 degrees
// - forward cosine: centre 0, half width 85, settings ignored
// - backward cosine: centre 180, half width 85
// - sine: centre 90 forward, -90 backward, half width 85
// - sine plus 45: centre 45 forward, -135 backward, half width 85
// - centre setting whole degrees -180 to 180, default 60
// - released stage outputs appear as general start and trip
module dfg_gate
  import dfg_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic              meas_valid,
  input  wire dfg_meas_type      meas,
  input  wire logic              stage_start,
  input  wire logic              stage_trip,
  output logic                   general_start,
  output logic                   general_trip,
  output logic                   direction_decision,
  output logic                   eval_done
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  dfg_state_type      state_reg;
  dfg_state_type      state_next;
  dfg_meas_type       meas_reg;
  dfg_dir_type        dir_reg;
  logic [7:0]         umin_reg;
  logic [7:0]         imin_reg;
  logic [7:0]         opang_reg;
  logic signed [8:0]  chang_reg;
  logic               waitrequest_reg;
  logic [31:0]        readdata_reg;
  logic               enable_reg;
  logic               decision_reg;
  logic               start_reg;
  logic               trip_reg;
  logic               done_reg;
  logic signed [15:0] angle_reg;
  logic signed [15:0] cordic_angle;
  logic               cordic_done;

  function automatic logic [7:0] clamp_u(input logic [31:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
    if (v < {24'h0, lo}) return lo;
    if (v > {24'h0, hi}) return hi;
    return v[7:0];
  endfunction : clamp_u

  // ------------------------------------------------------------
  // bus slave: one wait cycle, then the access completes
  // ------------------------------------------------------------
  wire        req      = read | write;
  wire        wr_fire  = write & ~waitrequest_reg;
  wire signed [31:0] wd_s = writedata;
  wire [8:0]  chang_wr = (wd_s < CHANG_LO) ? 9'(CHANG_LO) :
                         (wd_s > CHANG_HI) ? 9'(CHANG_HI) : writedata[8:0];
  wire [31:0] stat_word = {angle_reg, 12'h000, trip_reg, start_reg, decision_reg,
                           enable_reg};
  wire [31:0] rd_mux =
    (address == OFS_DIR)   ? {28'h0, dir_reg} :
    (address == OFS_UMIN)  ? {24'h0, umin_reg} :
    (address == OFS_IMIN)  ? {24'h0, imin_reg} :
    (address == OFS_OPANG) ? {24'h0, opang_reg} :
    (address == OFS_CHANG) ? {{23{chang_reg[8]}}, chang_reg} :
    (address == OFS_STAT)  ? stat_word : 32'h0000_0000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waitrequest_reg <= 1'b1;
      readdata_reg    <= 32'h0000_0000;
    end else begin
      waitrequest_reg <= ~(req & waitrequest_reg);
      if (req & waitrequest_reg) begin
        readdata_reg <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // settings
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dir_reg   <= DIR_FWD_ANG;
      umin_reg  <= UMIN_RST;
      imin_reg  <= IMIN_RST;
      opang_reg <= OPANG_RST;
      chang_reg <= CHANG_RST;
    end else if (wr_fire) begin
      if (address == OFS_DIR && writedata <= 32'(DIR_BWD_S45)) begin
        dir_reg <= dfg_dir_type'(writedata[3:0]);
      end
      if (address == OFS_UMIN) begin
        umin_reg <= clamp_u(writedata, UMIN_LO, UMIN_HI);
      end
      if (address == OFS_IMIN) begin
        imin_reg <= clamp_u(writedata, IMIN_LO, IMIN_HI);
      end
      if (address == OFS_OPANG) begin
        opang_reg <= clamp_u(writedata, OPANG_LO, OPANG_HI);
      end
      if (address == OFS_CHANG) begin
        chang_reg <= chang_wr;
      end
    end
  end

  // ------------------------------------------------------------
  // phasor product and angle
  // ------------------------------------------------------------
  // negated current
  // voltage is the reference: angle of -I * conj(U)
  wire signed [33:0] p_re = -(34'(meas_reg.i_re * meas_reg.u_re)
                              + 34'(meas_reg.i_im * meas_reg.u_im));
  wire signed [33:0] p_im = -(34'(meas_reg.i_im * meas_reg.u_re)
                              - 34'(meas_reg.i_re * meas_reg.u_im));

  dfg_cordic #(
    .W (36)
  ) u_cordic (
    .clock (clock),
    .rst   (rst),
    .start (state_reg == ST_MULT),
    .x_in  (36'(p_re)),
    .y_in  (36'(p_im)),
    .angle (cordic_angle),
    .done  (cordic_done)
  );

  // ------------------------------------------------------------
  // magnitude enables
  // ------------------------------------------------------------
  wire [15:0] u_thr  = 16'(umin_reg) * MAG_PER_PCT;
  wire [15:0] i_thr  = 16'(imin_reg) * MAG_PER_PCT;
  wire        mag_ok = (meas_reg.u_mag > u_thr) && (meas_reg.i_mag > i_thr);

  // ------------------------------------------------------------
  // operate window
  // ------------------------------------------------------------
  wire signed [17:0] user_c = 18'(chang_reg) <<< ANG_SHIFT;
  wire signed [17:0] user_b = (user_c > 18'sh0) ? user_c - ANG_180 : user_c + ANG_180;
  wire signed [17:0] user_w = 18'({10'h0, opang_reg}) <<< ANG_SHIFT;
  // backward angle, centre shifted by 180
  wire signed [17:0] centre =
    (dir_reg == DIR_FWD_ANG) ? user_c :
    (dir_reg == DIR_BWD_ANG) ? user_b :
    (dir_reg == DIR_BWD_COS) ? ANG_180 :
    (dir_reg == DIR_FWD_SIN) ? ANG_90 :
    (dir_reg == DIR_BWD_SIN) ? -ANG_90 :
    (dir_reg == DIR_FWD_S45) ? ANG_45 :
    (dir_reg == DIR_BWD_S45) ? -ANG_135 : 18'sh0;
  wire               user_sel = (dir_reg == DIR_FWD_ANG) || (dir_reg == DIR_BWD_ANG);
  wire signed [17:0] half_w   = user_sel ? user_w : ANG_FIX_W;
  wire signed [17:0] diff_raw = 18'(cordic_angle) - centre;
  wire signed [17:0] diff     = (diff_raw > ANG_180)  ? diff_raw - ANG_360 :
                                (diff_raw < -ANG_180) ? diff_raw + ANG_360 : diff_raw;
  wire               in_win   = (diff <= half_w) && (diff >= -half_w);
  wire               release_now = (dir_reg == DIR_NO_DIRECTION) || (mag_ok && in_win);

  // ------------------------------------------------------------
  // evaluation sequence per measurement update
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:   if (meas_valid) state_next = ST_MULT;
      ST_MULT:   state_next = ST_ROT;
      ST_ROT:    if (cordic_done) state_next = ST_DECIDE;
      ST_DECIDE: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      meas_reg     <= '0;
      enable_reg   <= 1'b0;
      decision_reg <= 1'b0;
      start_reg    <= 1'b0;
      trip_reg     <= 1'b0;
      done_reg     <= 1'b0;
      angle_reg    <= 16'sh0000;
    end else begin
      state_reg <= state_next;
      done_reg  <= state_reg == ST_DECIDE;
      if (state_reg == ST_IDLE && meas_valid) begin
        meas_reg <= meas;
      end
      if (state_reg == ST_DECIDE) begin
        enable_reg   <= mag_ok;
        decision_reg <= release_now;
        angle_reg    <= cordic_angle;
        start_reg    <= stage_start & release_now;
        trip_reg     <= stage_trip & release_now;
      end
    end
  end

  assign readdata           = readdata_reg;
  assign waitrequest        = waitrequest_reg;
  assign general_start      = start_reg;
  assign general_trip       = trip_reg;
  assign direction_decision = decision_reg;
  assign eval_done          = done_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_take;
    state_reg == ST_IDLE && meas_valid;
  endsequence
  sequence s_decide;
    state_reg == ST_DECIDE;
  endsequence

  property p_latency;
    s_take |-> ##16 eval_done;
  endproperty
  a_latency: assert property (p_latency) else $error("update not evaluated in time");

  property p_free;
    s_decide and dir_reg == DIR_NO_DIRECTION |=> direction_decision;
  endproperty
  a_free: assert property (p_free) else $error("undirected mode did not release");

  property p_no_mag;
    s_decide and !mag_ok and dir_reg != DIR_NO_DIRECTION |=> !direction_decision;
  endproperty
  a_no_mag: assert property (p_no_mag) else $error("release without magnitude enable");

  property p_held_low;
    s_decide and !release_now |=> !general_start && !general_trip;
  endproperty
  a_held_low: assert property (p_held_low) else $error("stage output not held low");

  property p_follow;
    s_decide and release_now and stage_trip |=> general_trip;
  endproperty
  a_follow: assert property (p_follow) else $error("released trip not passed");

  property p_start_gated;
    general_start |-> direction_decision;
  endproperty
  a_start_gated: assert property (p_start_gated) else $error("start without release");

  property p_imin_clamp;
    wr_fire && address == OFS_IMIN && writedata > 32'd50 |=> imin_reg == IMIN_HI;
  endproperty
  a_imin_clamp: assert property (p_imin_clamp) else $error("current min not clamped");

  property p_dir_keep;
    wr_fire && address == OFS_DIR && writedata > 32'd8 |=> $stable(dir_reg);
  endproperty
  a_dir_keep: assert property (p_dir_keep) else $error("illegal selection accepted");

  property p_cos_fix;
    dir_reg == DIR_FWD_COS |-> centre == 18'sh0 && half_w == 18'sh01540;
  endproperty
  a_cos_fix: assert property (p_cos_fix) else $error("cosine window wrong");

  property p_bwd;
    dir_reg == DIR_BWD_ANG && chang_reg == 9'sd0 |-> centre == 18'sh02d00;
  endproperty
  a_bwd: assert property (p_bwd) else $error("backward centre wrong");

  property p_bus;
    req && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer timing wrong");

endmodule : dfg_gate

// ===== logic/dfg_pkg.sv
// shared constants, types and register map of the directional earth-fault gate
package dfg_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_DIR       = 8'h00;
  localparam logic [7:0]  OFS_UMIN      = 8'h04;
  localparam logic [7:0]  OFS_IMIN      = 8'h08;
  localparam logic [7:0]  OFS_OPANG     = 8'h0c;
  localparam logic [7:0]  OFS_CHANG     = 8'h10;
  localparam logic [7:0]  OFS_STAT      = 8'h14;

  // ------------------------------------------------------------
  // setting ranges and reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  UMIN_LO       = 8'h01;
  localparam logic [7:0]  UMIN_HI       = 8'h14;
  localparam logic [7:0]  UMIN_RST      = 8'h02;
  localparam logic [7:0]  IMIN_LO       = 8'h01;
  localparam logic [7:0]  IMIN_HI       = 8'h32;
  localparam logic [7:0]  IMIN_RST      = 8'h05;
  localparam logic [7:0]  OPANG_LO      = 8'h1e;
  localparam logic [7:0]  OPANG_HI      = 8'h55;
  localparam logic [7:0]  OPANG_RST     = 8'h3c;
  localparam int          CHANG_LO      = -180;
  localparam int          CHANG_HI      = 180;
  localparam logic [8:0]  CHANG_RST     = 9'h03c;
  localparam logic [15:0] MAG_PER_PCT   = 16'h0064;

  // ------------------------------------------------------------
  // angle arithmetic, 1/64 degree per lsb
  // ------------------------------------------------------------
  localparam int                 ANG_SHIFT = 6;
  localparam logic signed [17:0] ANG_180   = 18'sh02d00;
  localparam logic signed [17:0] ANG_360   = 18'sh05a00;
  localparam logic signed [17:0] ANG_90    = 18'sh01680;
  localparam logic signed [17:0] ANG_45    = 18'sh00b40;
  localparam logic signed [17:0] ANG_135   = 18'sh021c0;
  localparam logic signed [17:0] ANG_FIX_W = 18'sh01540;
  localparam int                 CORDIC_ITER = 12;
  localparam logic signed [15:0] ATAN_TAB [CORDIC_ITER] = '{
    16'sh0b40, 16'sh06a4, 16'sh0382, 16'sh01c8, 16'sh00e5, 16'sh0073,
    16'sh0039, 16'sh001d, 16'sh000e, 16'sh0007, 16'sh0004, 16'sh0002};

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    DIR_NO_DIRECTION = 4'h0, DIR_FWD_ANG = 4'h1, DIR_BWD_ANG = 4'h2,
    DIR_FWD_COS = 4'h3, DIR_BWD_COS = 4'h4, DIR_FWD_SIN = 4'h5,
    DIR_BWD_SIN = 4'h6, DIR_FWD_S45 = 4'h7, DIR_BWD_S45 = 4'h8
  } dfg_dir_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_MULT = 2'b01, ST_ROT = 2'b11, ST_DECIDE = 2'b10
  } dfg_state_type;

  // fundamental phasors and magnitudes, magnitude lsb = 0.01 % of rated
  typedef struct packed {
    logic signed [15:0] u_re;
    logic signed [15:0] u_im;
    logic signed [15:0] i_re;
    logic signed [15:0] i_im;
    logic        [15:0] u_mag;
    logic        [15:0] i_mag;
  } dfg_meas_type;

endpackage : dfg_pkg

// ===== logic/dfg_cordic.sv
// iterative vectoring cordic: angle of (x, y) in 1/64 degree
`timescale 1ns/100ps
module dfg_cordic
  import dfg_pkg::*;
#(
  parameter int W = 36
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                start,
  input  wire logic signed [W-1:0] x_in,
  input  wire logic signed [W-1:0] y_in,
  output logic signed [15:0]       angle,
  output logic                     done
);

  logic signed [W-1:0] x_reg;
  logic signed [W-1:0] y_reg;
  logic signed [15:0]  z_reg;
  logic [3:0]          cnt_reg;
  logic                busy_reg;
  logic                done_reg;

  // ------------------------------------------------------------
  // pre-rotation into the right half plane
  // ------------------------------------------------------------
  wire                 x_neg   = x_in[W-1];
  wire signed [W-1:0]  x0      = x_neg ? -x_in : x_in;
  wire signed [W-1:0]  y0      = x_neg ? -y_in : y_in;
  wire signed [15:0]   z0      = !x_neg ? 16'sh0000 :
                                 (y_in[W-1] ? -ANG_180[15:0] : ANG_180[15:0]);
  wire signed [W-1:0]  x_sh    = x_reg >>> cnt_reg;
  wire signed [W-1:0]  y_sh    = y_reg >>> cnt_reg;
  wire                 y_pos   = !y_reg[W-1];
  wire                 last    = cnt_reg == 4'(CORDIC_ITER - 1);

  // ------------------------------------------------------------
  // micro-rotations, one per clock
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      x_reg    <= '0;
      y_reg    <= '0;
      z_reg    <= 16'sh0000;
      cnt_reg  <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (start) begin
      x_reg    <= x0;
      y_reg    <= y0;
      z_reg    <= z0;
      cnt_reg  <= 4'h0;
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
    end else if (busy_reg) begin
      x_reg    <= y_pos ? x_reg + y_sh : x_reg - y_sh;
      y_reg    <= y_pos ? y_reg - x_sh : y_reg + x_sh;
      z_reg    <= y_pos ? z_reg + ATAN_TAB[cnt_reg] : z_reg - ATAN_TAB[cnt_reg];
      cnt_reg  <= cnt_reg + 4'h1;
      busy_reg <= !last;
      done_reg <= last;
    end else begin
      done_reg <= 1'b0;
    end
  end

  assign angle = z_reg;
  assign done  = done_reg;

endmodule : dfg_cordic

// ===== dv/dfg_meas_source.sv
// partner model: upstream phasor source and non-directional stage
`timescale 1ns/100ps
module dfg_meas_source
  import dfg_pkg::*;
(
  input  wire logic    clock,
  output logic         meas_valid,
  output dfg_meas_type meas,
  output logic         stage_start,
  output logic         stage_trip
);
  // ----------------------------------------
  // source behaviour
  // ----------------------------------------
  initial begin
    meas_valid  = 1'b0;
    meas        = '0;
    stage_start = 1'b0;
    stage_trip  = 1'b0;
  end

  // fundamental phasors offered
  // meas is inverted after the take edge: the gate must latch, not track
  task automatic send(input dfg_meas_type m, input logic ss, input logic st,
                      input int lag, input bit junk);
    repeat (lag) @(posedge clock);
    meas_valid  <= 1'b1;
    meas        <= m;
    stage_start <= ss;
    stage_trip  <= st;
    @(posedge clock);
    meas_valid <= 1'b0;
    meas       <= ~m;
    if (junk) begin
      repeat (3) @(posedge clock);
      meas_valid <= 1'b1;
      @(posedge clock);
      meas_valid <= 1'b0;
    end
  endtask : send
endmodule : dfg_meas_source

// ===== dv/directional_earth_fault_gate_bench.sv
// self-checking bench of the directional earth-fault gate
`timescale 1ns/100ps
module directional_earth_fault_gate_bench
  import dfg_pkg::*;
;
  localparam real PI = 3.14159265358979;
  logic         clock, rst, read, write, waitrequest, meas_valid, stage_start, stage_trip;
  logic         general_start, general_trip, direction_decision, eval_done;
  logic [7:0]   address;
  logic [31:0]  writedata, readdata, rd, seed;
  dfg_meas_type meas;
  int           n_fail, n_tests, s_dir, s_umin, s_imin, s_op, s_ch;

  dfg_gate dut (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .meas_valid(meas_valid), .meas(meas), .stage_start(stage_start), .stage_trip(stage_trip),
    .general_start(general_start), .general_trip(general_trip),
    .direction_decision(direction_decision), .eval_done(eval_done));
  dfg_meas_source src (.clock(clock), .meas_valid(meas_valid), .meas(meas),
    .stage_start(stage_start), .stage_trip(stage_trip));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic results;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk_bit(string nm, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  // one degree of slack covers cordic steps and phasor rounding
  task automatic chk_ang(string nm, int e, logic signed [15:0] g);
    int d;
    d = int'(g) - e;
    if (d > int'(ANG_180)) d -= int'(ANG_360);
    if (d < -int'(ANG_180)) d += int'(ANG_360);
    n_tests++;
    if (^g === 1'bx || d > (1 << ANG_SHIFT) || d < -(1 << ANG_SHIFT)) begin
      n_fail++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_ang

  function automatic int rnd(int lo, int hi);
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h00000000);
    return lo + int'(seed[15:0]) % (hi - lo + 1);
  endfunction : rnd

  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge clock);
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0 && k < 40);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      n_fail++;
      results();
    end
  endtask : bus

  task automatic wr_rd(logic [7:0] a, logic [31:0] d, logic [31:0] e, string nm);
    bus(1'b1, a, d);
    bus(1'b0, a, 32'h0);
    chk_word(nm, e, rd);
  endtask : wr_rd

  task automatic set_cfg(int dir, int um, int im, int op, int ch);
    s_dir  = dir;
    s_umin = um;
    s_imin = im;
    s_op   = op;
    s_ch   = ch;
    bus(1'b1, OFS_DIR, dir);
    bus(1'b1, OFS_UMIN, um);
    bus(1'b1, OFS_IMIN, im);
    bus(1'b1, OFS_OPANG, op);
    bus(1'b1, OFS_CHANG, ch);
  endtask : set_cfg

  // 0 blocked, 1 released, 2 too close to the window edge to judge
  function automatic int expect_rel(real ang, int um, int im);
    real c, d;
    int  hw;
    if (s_dir == 0) return 1;
    if (!(um > s_umin * 100 && im > s_imin * 100)) return 0;
    c  = (s_dir == 1) ? s_ch : (s_dir == 2) ? s_ch + 180 : (s_dir == 3) ? 0 :
         (s_dir == 4) ? 180 : (s_dir == 5) ? 90 : (s_dir == 6) ? -90 :
         (s_dir == 7) ? 45 : -135;
    hw = (s_dir <= 2) ? s_op : 85;
    d  = ang - c;
    while (d >= 180.0) d -= 360.0;
    while (d < -180.0) d += 360.0;
    if (d < 0.0) d = -d;
    if (d - hw < 1.0 && hw - d < 1.0) return 2;
    return (d <= hw) ? 1 : 0;
  endfunction : expect_rel

  task automatic eval_once(int ua, int ia, int um, int im, logic ss, logic st, int lag,
                           bit junk);
    dfg_meas_type m;
    int           e, k, a_exp;
    logic         mok;
    m.u_re  = 16'($rtoi(8000.0 * $cos(ua * PI / 180.0)));
    m.u_im  = 16'($rtoi(8000.0 * $sin(ua * PI / 180.0)));
    m.i_re  = 16'($rtoi(6000.0 * $cos(ia * PI / 180.0)));
    m.i_im  = 16'($rtoi(6000.0 * $sin(ia * PI / 180.0)));
    m.u_mag = 16'(um);
    m.i_mag = 16'(im);
    mok = (um > s_umin * 100) && (im > s_imin * 100);
    // current enters negated, voltage is the reference
    e = expect_rel(ia + 180 - ua, um, im);
    a_exp = ((ia + 180 - ua) % 360 + 540) % 360 - 180;
    src.send(m, ss, st, lag, junk);
    k = 0;
    while (eval_done !== 1'b1 && k < 40) begin
      @(posedge clock);
      k++;
    end
    if (eval_done !== 1'b1) begin
      n_fail++;
      results();
    end
    if (e != 2) begin
      chk_bit("decision", e[0], direction_decision);
      chk_bit("start", e[0] & ss, general_start);
      chk_bit("trip", e[0] & st, general_trip);
    end
    bus(1'b0, OFS_STAT, 32'h0);
    chk_bit("mag_enable", mok, rd[0]);
    if (e != 2) chk_bit("held_start", e[0] & ss, rd[2]);
    if (e != 2) chk_bit("held_decision", e[0], rd[1]);
    if (e != 2) chk_bit("held_trip", e[0] & st, rd[3]);
    chk_ang("angle", a_exp * (1 << ANG_SHIFT), rd[31:16]);
  endtask : eval_once

  // ----------------------------------------
  // clock and sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    rst       = 1'b1;
    read      = 1'b0;
    write     = 1'b0;
    address   = 8'h00;
    writedata = 32'h0;
    seed      = 32'h72e01d57;
    n_fail    = 0;
    n_tests   = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    chk_bit("start_rst", 1'b0, general_start);
    bus(1'b0, OFS_DIR, 32'h0);
    chk_word("dir_rst", 32'h1, rd);
    bus(1'b0, OFS_UMIN, 32'h0);
    chk_word("umin_rst", 32'(UMIN_RST), rd);
    bus(1'b0, OFS_IMIN, 32'h0);
    chk_word("imin_rst", 32'(IMIN_RST), rd);
    bus(1'b0, OFS_OPANG, 32'h0);
    chk_word("opang_rst", 32'(OPANG_RST), rd);
    bus(1'b0, OFS_CHANG, 32'h0);
    chk_word("chang_rst", {{23{CHANG_RST[8]}}, CHANG_RST}, rd);
    wr_rd(8'h18, 32'h5, 32'h0, "unmapped");
    wr_rd(OFS_UMIN, 32'd25, 32'(UMIN_HI), "umin_hi");
    wr_rd(OFS_UMIN, 32'd0, 32'(UMIN_LO), "umin_lo");
    wr_rd(OFS_IMIN, 32'd99, 32'(IMIN_HI), "imin_hi");
    wr_rd(OFS_OPANG, 32'd10, 32'(OPANG_LO), "opang_lo");
    wr_rd(OFS_CHANG, 32'd200, 32'd180, "chang_hi");
    wr_rd(OFS_CHANG, 32'hffffff4c, 32'hffffff4c, "chang_neg");
    wr_rd(OFS_DIR, 32'd9, 32'h1, "dir_bad");
    set_cfg(0, 2, 5, 60, 60);
    eval_once(0, 90, 0, 0, 1'b1, 1'b1, 0, 1'b0);
    set_cfg(3, 2, 5, 60, 60);
    eval_once(0, 180, 200, 600, 1'b1, 1'b1, 0, 1'b0);
    eval_once(0, 180, 201, 600, 1'b1, 1'b1, 0, 1'b1);
    eval_once(0, 180, 201, 500, 1'b1, 1'b0, 2, 1'b0);
    set_cfg(2, 2, 5, 85, 180);
    eval_once(0, -170, 900, 900, 1'b1, 1'b1, 0, 1'b0);
    for (int md = 0; md < 9; md++) begin
      repeat (6) begin
        set_cfg(md, rnd(1, 20), rnd(1, 50), rnd(30, 85), rnd(-180, 180));
        eval_once(rnd(-180, 179), rnd(-180, 179), rnd(0, 2500), rnd(0, 6000),
                  1'(rnd(0, 1)), 1'(rnd(0, 1)), rnd(0, 3),
                  rnd(0, 4) == 0);
      end
    end
    results();
  end
endmodule : directional_earth_fault_gate_bench
